// File: rtl/cfg_port_pkg.sv
/*
  Shared constants and types of the serial programming port: bus address,
  command codes, register set size, event kinds and state enumerations.
  Assumes a single register image of REG_COUNT bytes and three stored
  images in the non-volatile store.
*/

package cfg_port_pkg;

  // ----------------------------------------------------------------------
  // Bus framing
  // ----------------------------------------------------------------------
  localparam logic [6:0] SLAVE_ADDR    = 7'h6a;
  localparam logic [7:0] IDENTIFIER_BYTE_VALUE = 8'h5a; // Arbitrary identifier
  localparam int         BYTE_W        = 8;
  localparam int         BIT_CNT_W     = 4;
  localparam logic [3:0] ACK_SLOT      = 4'h8;  // Ninth clock of a byte
  localparam logic [3:0] FIRST_BIT_CNT = 4'h1;

  // ----------------------------------------------------------------------
  // Commands and select decode
  // ----------------------------------------------------------------------
  localparam logic [1:0] CMD_WRITE   = 2'h0;
  localparam logic [1:0] CMD_SAVE    = 2'h1;
  localparam logic [1:0] CMD_RESTORE = 2'h2;
  localparam logic [1:0] CMD_NONE    = 2'h3;
  localparam logic [1:0] SEL_SLEEP   = 2'h0;
  localparam logic [1:0] SEL_OFFSET  = 2'h1;  // Pin code minus one = image

  // ----------------------------------------------------------------------
  // Register image and non-volatile store
  // ----------------------------------------------------------------------
  localparam int         PTR_W          = 8;
  localparam int         REG_COUNT      = 256;
  localparam int         BANK_COUNT     = 3;
  localparam logic [7:0] LAST_REG       = 8'hff;
  localparam logic [7:0] NVM_WORD_WAIT  = 8'h03; // Cycles per word minus one
  localparam logic [1:0] SYNC_WARM      = 2'h3;  // Pin pipeline fill time

  typedef enum logic [2:0] {
    EV_CMD, EV_PTR, EV_DATA, EV_EXTRA, EV_READ
  } link_event_t;

  typedef enum logic [2:0] {
    P_IDLE, P_ADDR, P_CMD, P_PTR, P_DATA, P_EXTRA, P_READ
  } link_phase_t;

  typedef enum logic [1:0] {
    ST_BOOT, ST_IDLE, ST_SAVE, ST_RESTORE
  } op_state_t;

endpackage : cfg_port_pkg

// File: rtl/cfg_serial_link.sv
/*
  Link end of the programming port, clocked by the serial clock itself.
  Shifts bytes in and out, decides acknowledges and hands each acknowledged
  command, pointer or data byte, each extra byte and each read byte after
  the identifier to the system side as a toggle with kind and byte held stable.
  Assumes the system side refreshes rd_byte within one high phase of scl.
*/
`timescale 1ns/1ps

module cfg_serial_link (
  input  wire logic                      rst,
  input  wire logic                      scl,
  input  wire logic                      sda_in,
  input  wire logic                      busy,
  input  wire logic [7:0]                rd_byte,
  output logic                           ev_toggle,
  output cfg_port_pkg::link_event_t      ev_kind,
  output logic [7:0]                     ev_byte,
  output logic                           sda_oe_n
);

  logic                      start_tgl;
  logic                      start_seen;
  logic                      busy_meta;
  logic                      busy_sync;
  logic [3:0]                bit_cnt;
  logic [7:0]                shreg;
  logic                      tx_is_id;
  logic                      want_ack;
  logic                      byte_done;
  logic                      start_pend;
  logic [7:0]                tx_byte;
  cfg_port_pkg::link_phase_t phase;

  // ----------------------------------------------------------------------
  // Start detection
  // ----------------------------------------------------------------------
  // Data falling while clock high; also covers repeated start
  always_ff @(negedge sda_in or posedge rst)
  begin
    if (rst)
      start_tgl <= 1'b0;
    else if (scl)
      start_tgl <= ~start_tgl;
  end

  // Busy level crosses on the serial clock
  always_ff @(posedge scl or posedge rst)
  begin
    if (rst)
    begin
      busy_meta <= 1'b1;
      busy_sync <= 1'b1;
    end
    else
    begin
      busy_meta <= busy;
      busy_sync <= busy_meta;
    end
  end

  // Acknowledge decision for the byte just shifted in
  assign start_pend = start_tgl != start_seen;
  assign byte_done  = bit_cnt == cfg_port_pkg::ACK_SLOT;
  assign tx_byte    = tx_is_id ? cfg_port_pkg::IDENTIFIER_BYTE_VALUE : rd_byte;
  always_comb
  begin
    want_ack = 1'b0;
    case (phase)
      cfg_port_pkg::P_ADDR:
        want_ack = shreg[7:1] == cfg_port_pkg::SLAVE_ADDR;
      cfg_port_pkg::P_CMD:
        want_ack = shreg[1:0] != cfg_port_pkg::CMD_NONE;
      cfg_port_pkg::P_PTR,
      cfg_port_pkg::P_DATA:
        want_ack = 1'b1;
      default:
        want_ack = 1'b0;
    endcase
    want_ack = want_ack & ~busy_sync;
  end

  // ----------------------------------------------------------------------
  // Frame sequencing on the rising clock
  // ----------------------------------------------------------------------
  always_ff @(posedge scl or posedge rst)
  begin
    if (rst)
    begin
      start_seen <= 1'b0;
      phase      <= cfg_port_pkg::P_IDLE;
      bit_cnt    <= '0;
      shreg      <= '0;
      tx_is_id   <= 1'b0;
      ev_toggle  <= 1'b0;
      ev_kind    <= cfg_port_pkg::EV_CMD;
      ev_byte    <= '0;
    end
    else if (start_pend)
    begin
      start_seen <= start_tgl;
      phase      <= cfg_port_pkg::P_ADDR;
      bit_cnt    <= cfg_port_pkg::FIRST_BIT_CNT;
      shreg      <= {7'h00, sda_in};
    end
    else if (phase == cfg_port_pkg::P_IDLE)
      bit_cnt <= '0;
    else if (!byte_done)
    begin
      shreg   <= {shreg[6:0], sda_in};
      bit_cnt <= bit_cnt + 4'h1;
    end
    else
    begin
      bit_cnt <= '0;
      ev_byte <= shreg;
      case (phase)
        cfg_port_pkg::P_ADDR:
        begin
          tx_is_id <= 1'b1;
          if (!want_ack)
            phase <= cfg_port_pkg::P_IDLE;
          else if (shreg[0])
            phase <= cfg_port_pkg::P_READ;
          else
            phase <= cfg_port_pkg::P_CMD;
        end
        cfg_port_pkg::P_CMD:
        begin
          if (!want_ack)
            phase <= cfg_port_pkg::P_IDLE;
          else
          begin
            ev_toggle <= ~ev_toggle;
            ev_kind   <= cfg_port_pkg::EV_CMD;
            if (shreg[1:0] == cfg_port_pkg::CMD_WRITE)
              phase <= cfg_port_pkg::P_PTR;
            else
              phase <= cfg_port_pkg::P_EXTRA;
          end
        end
        cfg_port_pkg::P_PTR,
        cfg_port_pkg::P_DATA:
        begin
          if (!want_ack)
            phase <= cfg_port_pkg::P_IDLE;
          else
          begin
            ev_toggle <= ~ev_toggle;
            ev_kind   <= (phase == cfg_port_pkg::P_PTR) ?
                         cfg_port_pkg::EV_PTR : cfg_port_pkg::EV_DATA;
            phase     <= cfg_port_pkg::P_DATA;
          end
        end
        cfg_port_pkg::P_EXTRA:
        begin
          ev_toggle <= ~ev_toggle;
          ev_kind   <= cfg_port_pkg::EV_EXTRA;
        end
        cfg_port_pkg::P_READ:
        begin
          tx_is_id <= 1'b0;
          if (!tx_is_id)
          begin
            ev_toggle <= ~ev_toggle;
            ev_kind   <= cfg_port_pkg::EV_READ;
          end
          if (sda_in)
            phase <= cfg_port_pkg::P_IDLE;
        end
        default:
          phase <= cfg_port_pkg::P_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Data line drive on the falling clock
  // ----------------------------------------------------------------------
  // Only ever pulls low; a one bit is sent by releasing the line
  always_ff @(negedge scl or posedge rst)
  begin
    if (rst)
      sda_oe_n <= 1'b1;
    else if (start_pend)
      sda_oe_n <= 1'b1; // Stale phase must not drive after a start
    else if (phase == cfg_port_pkg::P_READ && !byte_done)
      sda_oe_n <= tx_byte[~bit_cnt[2:0]];
    else if (phase != cfg_port_pkg::P_READ && byte_done && want_ack)
      sda_oe_n <= 1'b0;
    else
      sda_oe_n <= 1'b1;
  end

endmodule : cfg_serial_link

// File: rtl/cfg_serial_prog_port.sv
/*
  Top of the serial programming port on the system clock. Holds the
  configuration register image, the three stored images, the pointer and
  the save/restore sequencer, and decodes the select pins.
  Assumes scl, sda and the select pins are asynchronous pins, and that the
  serial clock high phase is far longer than a few system clocks.
*/
`timescale 1ns/1ps

module cfg_serial_prog_port (
  input  wire logic       sys_clk,
  input  wire logic       rst,
  input  wire logic       scl,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe_n,
  input  wire logic       config_select_hi,
  input  wire logic       config_select_lo,
  input  wire logic [7:0] cfg_rd_addr,
  output logic [7:0]      cfg_rd_data,
  output logic [1:0]      active_setup,
  output logic            sleep_mode,
  output logic            clk_out_enable,
  output logic            cfg_busy
);

  logic                      scl_meta;
  logic                      scl_sync;
  logic                      scl_prev;
  logic                      sda_meta;
  logic                      sda_sync;
  logic                      sda_prev;
  logic [1:0]                sel_meta;
  logic [1:0]                sel_sync;
  logic                      ev_meta;
  logic                      ev_sync;
  logic                      ev_prev;
  logic                      ev_toggle;
  cfg_port_pkg::link_event_t ev_kind;
  logic [7:0]                ev_byte;
  logic                      ev_fire;
  logic                      bus_start;
  logic                      bus_stop;
  logic                      pend_valid;
  logic [1:0]                pend_code;
  logic                      launch;
  cfg_port_pkg::op_state_t   state;
  cfg_port_pkg::op_state_t   next_state;
  logic [1:0]                warm_cnt;
  logic [7:0]                copy_idx;
  logic [7:0]                wait_cnt;
  logic                      step;
  logic [1:0]                op_bank;
  logic [1:0]                sel_bank;
  logic [7:0]                ptr;
  logic [7:0]                rd_byte;
  logic                      link_busy;
  logic                      accept_ev;
  logic [7:0]                regs [cfg_port_pkg::REG_COUNT];
  logic [7:0]                nvm  [cfg_port_pkg::BANK_COUNT]
                                  [cfg_port_pkg::REG_COUNT];

  // ----------------------------------------------------------------------
  // Link end on the serial clock
  // ----------------------------------------------------------------------
  cfg_serial_link u_link (
    .rst       (rst),
    .scl       (scl),
    .sda_in    (sda_in),
    .busy      (link_busy),
    .rd_byte   (rd_byte),
    .ev_toggle (ev_toggle),
    .ev_kind   (ev_kind),
    .ev_byte   (ev_byte),
    .sda_oe_n  (sda_oe_n)
  );

  // Open-drain line: the only level ever driven is low
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      sda_out <= 1'b0;
    else
      sda_out <= 1'b0;
  end

  // ----------------------------------------------------------------------
  // Pin and event synchronisers
  // ----------------------------------------------------------------------
  // Bus lines watched here only for start and stop
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      scl_meta <= 1'b1;
      scl_sync <= 1'b1;
      scl_prev <= 1'b1;
      sda_meta <= 1'b1;
      sda_sync <= 1'b1;
      sda_prev <= 1'b1;
    end
    else
    begin
      scl_meta <= scl;
      scl_sync <= scl_meta;
      scl_prev <= scl_sync;
      sda_meta <= sda_in;
      sda_sync <= sda_meta;
      sda_prev <= sda_sync;
    end
  end

  // Select pins, first stage read by second only
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      sel_meta <= cfg_port_pkg::SEL_SLEEP;
      sel_sync <= cfg_port_pkg::SEL_SLEEP;
    end
    else
    begin
      sel_meta <= {config_select_hi, config_select_lo};
      sel_sync <= sel_meta;
    end
  end

  // Byte events arrive as a toggle; kind and byte are held by the link
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      ev_meta <= 1'b0;
      ev_sync <= 1'b0;
      ev_prev <= 1'b0;
    end
    else
    begin
      ev_meta <= ev_toggle;
      ev_sync <= ev_meta;
      ev_prev <= ev_sync;
    end
  end

  assign ev_fire   = ev_sync ^ ev_prev;
  assign accept_ev = ev_fire && state == cfg_port_pkg::ST_IDLE;
  assign bus_start = scl_sync & scl_prev & sda_prev & ~sda_sync;
  assign bus_stop  = scl_sync & scl_prev & ~sda_prev & sda_sync;

  // ----------------------------------------------------------------------
  // Select decode
  // ----------------------------------------------------------------------
  // Sleep code falls back to image zero for save and restore
  assign sel_bank = (sel_sync == cfg_port_pkg::SEL_SLEEP) ? 2'h0 :
                    sel_sync - cfg_port_pkg::SEL_OFFSET;

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      sleep_mode   <= 1'b0;
      active_setup <= 2'h0;
    end
    else if (state != cfg_port_pkg::ST_BOOT || // Pins not yet settled
             warm_cnt == cfg_port_pkg::SYNC_WARM)
    begin
      sleep_mode   <= sel_sync == cfg_port_pkg::SEL_SLEEP;
      active_setup <= sel_bank;
    end
  end

  // ----------------------------------------------------------------------
  // Pending save or restore
  // ----------------------------------------------------------------------
  // Armed by the command byte, fired only by the stop that follows it
  assign launch = pend_valid && bus_stop;

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      pend_valid <= 1'b0;
      pend_code  <= cfg_port_pkg::CMD_WRITE;
    end
    else if (accept_ev && ev_kind == cfg_port_pkg::EV_CMD)
    begin
      pend_valid <= ev_byte[1:0] == cfg_port_pkg::CMD_SAVE ||
                    ev_byte[1:0] == cfg_port_pkg::CMD_RESTORE;
      pend_code  <= ev_byte[1:0];
    end
    else if (accept_ev || bus_start || launch)
      pend_valid <= 1'b0;
  end

  // ----------------------------------------------------------------------
  // Save and restore sequencer
  // ----------------------------------------------------------------------
  assign step = wait_cnt == cfg_port_pkg::NVM_WORD_WAIT;

  always_comb
  begin
    next_state = state;
    case (state)
      cfg_port_pkg::ST_BOOT:
        if (warm_cnt == cfg_port_pkg::SYNC_WARM)
          next_state = cfg_port_pkg::ST_RESTORE;
      cfg_port_pkg::ST_IDLE:
        if (launch && pend_code == cfg_port_pkg::CMD_SAVE)
          next_state = cfg_port_pkg::ST_SAVE;
        else if (launch)
          next_state = cfg_port_pkg::ST_RESTORE;
      cfg_port_pkg::ST_SAVE,
      cfg_port_pkg::ST_RESTORE:
        if (step && copy_idx == cfg_port_pkg::LAST_REG)
          next_state = cfg_port_pkg::ST_IDLE;
      default:
        next_state = cfg_port_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      state <= cfg_port_pkg::ST_BOOT;
    else
      state <= next_state;
  end

  // Wait for the select pipeline before choosing the boot image
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      warm_cnt <= 2'h0;
    else if (state == cfg_port_pkg::ST_BOOT)
      warm_cnt <= warm_cnt + 2'h1;
  end

  // Image chosen once per operation so a pin change cannot split it
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      op_bank <= 2'h0;
    else if (state != next_state && (next_state == cfg_port_pkg::ST_SAVE ||
             next_state == cfg_port_pkg::ST_RESTORE))
      op_bank <= sel_bank;
  end

  // Word walk with a fixed store access time per word
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      copy_idx <= 8'h00;
      wait_cnt <= 8'h00;
    end
    else if (state == cfg_port_pkg::ST_SAVE ||
             state == cfg_port_pkg::ST_RESTORE)
    begin
      wait_cnt <= step ? 8'h00 : wait_cnt + 8'h01;
      if (step)
        copy_idx <= copy_idx + 8'h01;
    end
    else
    begin
      copy_idx <= 8'h00;
      wait_cnt <= 8'h00;
    end
  end

  // Busy toward the link and the outside: no acknowledges while set
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      link_busy <= 1'b1;
      cfg_busy  <= 1'b1;
    end
    else
    begin
      link_busy <= next_state != cfg_port_pkg::ST_IDLE;
      cfg_busy  <= next_state != cfg_port_pkg::ST_IDLE;
    end
  end

  // Clocks held off until a restore has loaded every register
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      clk_out_enable <= 1'b0;
    else
      clk_out_enable <= next_state != cfg_port_pkg::ST_RESTORE &&
                        next_state != cfg_port_pkg::ST_BOOT &&
                        sel_sync != cfg_port_pkg::SEL_SLEEP;
  end

  // ----------------------------------------------------------------------
  // Register pointer
  // ----------------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      ptr <= 8'h00;
    else if (accept_ev && ev_kind == cfg_port_pkg::EV_PTR)
      ptr <= ev_byte;
    else if (accept_ev && (ev_kind == cfg_port_pkg::EV_DATA ||
                           ev_kind == cfg_port_pkg::EV_READ))
      ptr <= ptr + 8'h01;
  end

  // ----------------------------------------------------------------------
  // Register image and stored images
  // ----------------------------------------------------------------------
  // Memories carry no reset; the boot restore fills the image
  always_ff @(posedge sys_clk)
  begin
    if (state == cfg_port_pkg::ST_RESTORE && step)
      regs[copy_idx] <= nvm[op_bank][copy_idx];
    else if (accept_ev && ev_kind == cfg_port_pkg::EV_DATA)
      regs[ptr] <= ev_byte;
  end

  always_ff @(posedge sys_clk)
  begin
    if (state == cfg_port_pkg::ST_SAVE && step)
      nvm[op_bank][copy_idx] <= regs[copy_idx];
  end

  // Read byte refreshed every cycle; the link samples it a bit at a time
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      rd_byte     <= 8'h00;
      cfg_rd_data <= 8'h00;
    end
    else
    begin
      rd_byte     <= regs[ptr];
      cfg_rd_data <= regs[cfg_rd_addr];
    end
  end

endmodule : cfg_serial_prog_port

// File: verif/cfg_port_props.sv
/*
  Pin checker of the serial programming port.
  Assumes it is bound to every instance of cfg_serial_prog_port.
*/
`timescale 1ns/1ps

module cfg_port_props (
  input wire logic       sys_clk,
  input wire logic       rst,
  input wire logic       scl,
  input wire logic       sda_out,
  input wire logic       sda_oe_n,
  input wire logic       config_select_hi,
  input wire logic       config_select_lo,
  input wire logic [1:0] active_setup,
  input wire logic       sleep_mode,
  input wire logic       clk_out_enable,
  input wire logic       cfg_busy
);
  logic [11:0] busy_len;
  wire  [1:0]  pins = {config_select_hi, config_select_lo};

  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);

  // Busy span; a short span means a partial image move
  always_ff @(posedge sys_clk or posedge rst)
    if (rst)
      busy_len <= 12'h000;
    else
      busy_len <= cfg_busy ? busy_len + 12'h001 : 12'h000;

  // ----------------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------------
  AST_SLEEP: assert property ((pins == 2'h0)[*5] |-> sleep_mode)
    else $error("sleep code not decoded");
  AST_SETUP: assert property ($stable(pins)[*5] |->
    active_setup == (pins == 2'h0 ? 2'h0 : pins - 2'h1))
    else $error("setup index wrong");
  AST_SLEEP_OFF: assert property (sleep_mode[*4] |-> !clk_out_enable)
    else $error("clocks on in sleep");
  AST_SDA_LOW: assert property (sda_out == 1'b0)
    else $error("data line driven high");
  AST_EDGE: assert property ($changed(sda_oe_n) |-> !scl)
    else $error("data changed with clock high");
  AST_QUIET: assert property (cfg_busy |-> sda_oe_n)
    else $error("acknowledge while busy");
  AST_BOOT: assert property ($fell(rst) |->
    (cfg_busy && !clk_out_enable)[*8])
    else $error("no boot restore");
  AST_LEN: assert property ($fell(cfg_busy) |->
    busy_len >= 12'h3fc && busy_len <= 12'h410)
    else $error("image move too short or long");
endmodule : cfg_port_props

bind cfg_serial_prog_port cfg_port_props u_props (.sys_clk, .rst, .scl,
  .sda_out, .sda_oe_n, .config_select_hi, .config_select_lo,
  .active_setup, .sleep_mode, .clk_out_enable, .cfg_busy);

// File: verif/i2c_master_model.sv
/*
  Bus master model for the serial pins.
  Assumes a pull-up on the data wire; 1 on sda_drv releases it.
*/
`timescale 1ns/1ps

module i2c_master_model (
  output logic      scl,
  output logic      sda_drv,
  input  wire logic sda_wire
);
  localparam time Q = 30; // Six 5 ns system clocks, keeps scl high >= 40 ns

  initial {scl, sda_drv} = 2'h3;

  // One bit slot; data moves only while scl is low
  task automatic bit_slot(input logic d, output logic s);
    sda_drv = d;
    #Q scl = 1'b1;
    #Q s = sda_wire;
    #Q scl = 1'b0;
    #Q;
  endtask : bit_slot

  // Start and repeated start alike
  task automatic start();
    sda_drv = 1'b1;
    #Q scl = 1'b1;
    #Q sda_drv = 1'b0;
    #Q scl = 1'b0;
    #Q;
  endtask : start

  task automatic stop();
    sda_drv = 1'b0;
    #Q scl = 1'b1;
    #Q sda_drv = 1'b1;
    #Q;
  endtask : stop

  task automatic wr_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
      bit_slot(b[i], s);
    bit_slot(1'b1, s);
    ack = ~s;
  endtask : wr_byte

  // Master acknowledges each byte, nacks the last
  task automatic rd_byte(input logic nack, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--)
      bit_slot(1'b1, b[i]);
    bit_slot(nack, s);
  endtask : rd_byte
endmodule : i2c_master_model

// File: verif/tb_config_serial_prog_port.sv
/*
  Self-checking bench of the programming port.
  Assumes the checker binds itself and the master model drives the pins.
*/
`timescale 1ns/1ps

module tb_config_serial_prog_port;
  logic       sys_clk;
  logic       rst;
  logic       config_select_hi;
  logic       config_select_lo;
  logic [7:0] cfg_rd_addr;
  logic [7:0] cfg_rd_data;
  logic [1:0] active_setup;
  logic       sleep_mode;
  logic       clk_out_enable;
  logic       cfg_busy;
  logic       scl;
  logic       sda_drv;
  logic       sda_out;
  logic       sda_oe_n;
  wire        sda = sda_drv & (sda_oe_n | sda_out);
  int         fails;
  int         samples_checked;
  logic [7:0] d [3];
  logic [7:0] p;
  logic [7:0] r;
  logic       a;

  cfg_serial_prog_port u_dut (.sys_clk, .rst, .scl, .sda_in(sda),
    .sda_out, .sda_oe_n, .config_select_hi, .config_select_lo,
    .cfg_rd_addr, .cfg_rd_data, .active_setup, .sleep_mode,
    .clk_out_enable, .cfg_busy);
  i2c_master_model u_mst (.scl, .sda_drv, .sda_wire(sda));

  initial
  begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      fails++;
      $display("unexpected at %0t: %h vs %h", $time, seen, exp);
    end
  endtask : check

  task automatic wrap_up();
    if (fails == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : wrap_up

  task automatic send(input logic [7:0] b, input logic exp);
    u_mst.wr_byte(b, a);
    check(8'(a), 8'(exp));
  endtask : send

  // Start, own address, command with random upper bits
  task automatic open_wr(input logic [1:0] op, input logic ok);
    u_mst.start();
    send({cfg_port_pkg::SLAVE_ADDR, 1'b0}, 1'b1);
    send({6'($urandom), op}, ok);
  endtask : open_wr

  task automatic peek(input logic [7:0] ad, input logic [7:0] exp);
    @(posedge sys_clk) cfg_rd_addr <= ad;
    repeat (3) @(posedge sys_clk);
    check(cfg_rd_data, exp);
  endtask : peek

  task automatic wait_idle();
    for (int i = 0; i < 1200 && cfg_busy !== 1'b0; i++)
      @(posedge sys_clk);
    check(8'(cfg_busy), 8'h00);
  endtask : wait_idle

  function automatic logic [7:0] sel_exp(input logic [1:0] c);
    return {5'h0, c == 2'h0, c == 2'h0 ? 2'h0 : c - 2'h1};
  endfunction : sel_exp

  // ----------------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------------
  initial
  begin
    {config_select_hi, config_select_lo} = 2'h3;
    rst = 1'b1;
    cfg_rd_addr = 8'h00;
    r = 8'($urandom(32'h5a87));
    repeat (16) @(posedge sys_clk);
    rst <= 1'b0;
    wait_idle();
    check(8'(clk_out_enable), 8'h01);
    u_mst.start();
    send({cfg_port_pkg::SLAVE_ADDR ^ 7'($urandom_range(1, 127)), 1'b0},
      1'b0);
    u_mst.stop();
    // Random pointer, then the wrap from the last register
    for (int k = 0; k < 2; k++)
    begin
      p = k ? 8'hff : 8'($urandom);
      open_wr(cfg_port_pkg::CMD_WRITE, 1'b1);
      send(p, 1'b1);
      foreach (d[j])
      begin
        d[j] = 8'($urandom);
        send(d[j], 1'b1);
      end
      u_mst.stop();
      foreach (d[j])
        peek(p + 8'(j), d[j]);
    end
    // Pointer set, repeated start, read back
    open_wr(cfg_port_pkg::CMD_WRITE, 1'b1);
    send(8'hff, 1'b1);
    u_mst.start();
    send({cfg_port_pkg::SLAVE_ADDR, 1'b1}, 1'b1);
    u_mst.rd_byte(1'b0, r);
    check(r, cfg_port_pkg::IDENTIFIER_BYTE_VALUE);
    u_mst.rd_byte(1'b0, r);
    check(r, d[0]);
    u_mst.rd_byte(1'b1, r);
    check(r, d[1]);
    u_mst.stop();
    open_wr(cfg_port_pkg::CMD_NONE, 1'b0);
    u_mst.stop();
    repeat (8) @(posedge sys_clk);
    check(8'(cfg_busy), 8'h00);
    // A byte after a save command is refused and cancels the save
    open_wr(cfg_port_pkg::CMD_SAVE, 1'b1);
    send(8'($urandom), 1'b0);
    u_mst.stop();
    repeat (8) @(posedge sys_clk);
    check(8'(cfg_busy), 8'h00);
    // Save, refused access while busy, overwrite, restore
    open_wr(cfg_port_pkg::CMD_SAVE, 1'b1);
    u_mst.stop();
    repeat (8) @(posedge sys_clk);
    check(8'(cfg_busy), 8'h01);
    u_mst.start();
    send({cfg_port_pkg::SLAVE_ADDR, 1'b0}, 1'b0);
    u_mst.stop();
    wait_idle();
    open_wr(cfg_port_pkg::CMD_WRITE, 1'b1);
    send(8'hff, 1'b1);
    send(~d[0], 1'b1);
    u_mst.stop();
    peek(8'hff, ~d[0]);
    open_wr(cfg_port_pkg::CMD_RESTORE, 1'b1);
    u_mst.stop();
    repeat (8) @(posedge sys_clk);
    check(8'(clk_out_enable), 8'h00);
    wait_idle();
    peek(8'hff, d[0]);
    // Every select code
    for (int c = 0; c < 4; c++)
    begin
      @(posedge sys_clk) {config_select_hi, config_select_lo} <= 2'(c);
      repeat (6) @(posedge sys_clk);
      check({5'h0, sleep_mode, active_setup}, sel_exp(2'(c)));
    end
    wrap_up();
  end

  // Run needs well under 150 us
  initial
  begin
    #300000;
    fails++;
    wrap_up();
  end
endmodule : tb_config_serial_prog_port
